/* design/uart_irq_regs.vh */
`ifndef UART_IRQ_REGS_VH
`define UART_IRQ_REGS_VH
// Register select addresses on the 3-bit CPU address
`define ADDR_DATA        3'h0
`define ADDR_MASK        3'h1
`define ADDR_SOURCE      3'h2
`define ADDR_LINE_STATUS 3'h5
`define ADDR_MODEM_STAT  3'h6
`define ADDR_GPIO_LEVEL  3'h7
// Interrupt mask field positions
`define MASK_RX_DATA     0
`define MASK_TX_READY    1
`define MASK_LINE_STAT   2
`define MASK_MODEM       3
`define MASK_SLEEP       4
`define MASK_XOFF        5
`define MASK_RTS         6
`define MASK_CTS         7
`define MASK_RESET       8'h00
`define MASK_ENH_BITS    8'hf0
// Source codes, bits 5..0
`define SRC_LINE_STAT    6'h06
`define SRC_RX_TIMEOUT   6'h0c
`define SRC_RX_DATA      6'h04
`define SRC_TX_READY     6'h02
`define SRC_MODEM        6'h00
`define SRC_FLOW_CHAR    6'h10
`define SRC_FLOW_PIN     6'h20
`define SRC_NONE         6'h01
// Receive timeout: 4 characters plus 12 bits
`define TIMEOUT_CHARS    4
`define TIMEOUT_BITS     12
`endif

/* design/uart_interrupt_mask_and_priority.v */
// What this block does
// - Receive data interrupt follows FIFO trigger level
// - Data ready set on entry, cleared empty
// - Line status reports overrun, errors, transmit empty
// - Mask bit 0 enables receive data interrupt
// - Mask bit 1 enables transmit ready interrupt
// - Mask bit 2 enables line status interrupt
// - Enhanced mode flags errors at FIFO entry
// - Mask bit 3 enables modem status interrupt
// - Mask bit 4 sleep, needs enhanced functions
// - Mask bit 5 stop character interrupt, enhanced
// - Mask bit 6 RTS rise interrupt, enhanced
// - Mask bit 7 CTS rise interrupt, enhanced
// - Receive timeout after four chars twelve bits
// - Transmit ready cleared by source read, write
// - Status reads clear line status and RTS/CTS pin interrupts
// - Receive data holds until fill below trigger
// - Flow character interrupt, cleared by source read
// - Wake-up reported as code none, read clears
// - GPIO interrupt on polarity-adjusted input, level read
// - Source code encodes highest pending source
// - Only highest priority shown; all but flow character and wake-up flags stay queued
// - Bit 7 FIFO enabled, bit 6 GPIO flag XOR FIFO enabled
// - Bits 4, 5 only with enhanced functions
`include "uart_irq_regs.vh"
module uart_interrupt_mask_and_priority (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [2:0]  addr,
  input  wire        rd_stb,
  input  wire        wr_stb,
  input  wire [7:0]  wr_data,
  input  wire        fifo_enable,
  input  wire        enhanced_enable,
  input  wire        enh_error_at_entry,
  input  wire        auto_rts_enable,
  input  wire        auto_cts_enable,
  input  wire        wake_enable,
  input  wire        rx_push,
  input  wire        rx_push_error,
  input  wire [7:0]  rx_fill,
  input  wire [7:0]  rx_trigger,
  input  wire        rx_errored_in_fifo,
  input  wire        rx_head_parity_err,
  input  wire        rx_head_framing_err,
  input  wire        rx_head_break,
  input  wire        overrun_event,
  input  wire        rx_bit_tick,
  input  wire [3:0]  char_bits,
  input  wire [7:0]  tx_fill,
  input  wire [7:0]  tx_trigger,
  input  wire        tx_shift_empty,
  input  wire [3:0]  modem_delta,
  input  wire        flow_char_event,
  input  wire        special_char_event,
  input  wire        rts_pin,
  input  wire        cts_pin,
  input  wire        wake_event,
  input  wire [7:0]  gpio_in,
  input  wire [7:0]  gpio_polarity,
  input  wire [7:0]  gpio_int_mask,
  output reg  [7:0]  interrupt_mask_q,
  output reg  [7:0]  interrupt_source_q,
  output reg  [7:0]  line_status_q,
  output reg         irq_q,
  output reg         sleep_enable_q
);

  reg [7:0]  gpio_s1_q;
  reg [7:0]  gpio_s2_q;
  reg [7:0]  gpio_prev_q;
  reg        cts_s1_q;
  reg        cts_s2_q;
  reg        cts_prev_q;
  reg        rts_prev_q;
  reg        ls_err_q;
  reg        overrun_q;
  reg        tx_ready_q;
  reg        tx_empty_prev_q;
  reg        flow_char_q;
  reg        special_q;
  reg        flow_pin_q;
  reg        wake_q;
  reg        gpio_q;
  reg        timeout_q;
  reg        head_err_prev_q;
  reg        data_rd_prev_q;
  reg [1:0]  sync_fill_q;
  reg [9:0]  timeout_cnt_q;
  reg [5:0]  code_d;
  reg [7:0]  mask_d;

  wire rd_data   = rd_stb && (addr == `ADDR_DATA);
  wire wr_data_r = wr_stb && (addr == `ADDR_DATA);
  wire rd_src    = rd_stb && (addr == `ADDR_SOURCE);
  wire rd_ls     = rd_stb && (addr == `ADDR_LINE_STATUS);
  wire rd_ms     = rd_stb && (addr == `ADDR_MODEM_STAT);
  wire rd_gpio   = rd_stb && (addr == `ADDR_GPIO_LEVEL);
  wire wr_mask   = wr_stb && (addr == `ADDR_MASK);

  wire rx_has   = (rx_fill != 8'h00);
  wire tx_empty = (tx_fill == 8'h00);
  wire head_err = rx_head_parity_err | rx_head_framing_err | rx_head_break;
  // Non-FIFO mode: one character is the trigger
  wire rx_trig  = fifo_enable ? (rx_fill >= rx_trigger) : rx_has;
  wire tx_trig  = fifo_enable ? (tx_fill < tx_trigger) : tx_empty;

  // Edge detectors idle until synchronisers hold pin values
  // Avoids a false event from a pin already active at reset
  wire       sync_ready = (sync_fill_q == 2'b11);
  wire [7:0] gpio_act  = gpio_s2_q ^ gpio_polarity;
  wire       gpio_rise = sync_ready &
                         (|(gpio_act & ~gpio_prev_q & gpio_int_mask));
  wire       cts_rise  = sync_ready & cts_s2_q & ~cts_prev_q & auto_cts_enable;
  wire       rts_rise  = sync_ready & rts_pin & ~rts_prev_q & auto_rts_enable;

  // Head error counts once per new head character, else a
  // status read could never clear it while the character waits
  wire head_new = head_err & (~head_err_prev_q | data_rd_prev_q);
  // Error raised at FIFO entry in enhanced mode
  wire err_set  = enh_error_at_entry ? (rx_push & rx_push_error) : head_new;
  // Timeout: 4 characters plus 12 bits, counted in bit ticks
  wire [9:0] timeout_lim = {2'b00, char_bits, 2'b00} + 10'd`TIMEOUT_BITS;

  // Low nibble always writable
  // Enhanced mask bits frozen unless enabled
  always @*
  begin
    mask_d = interrupt_mask_q;
    if (wr_mask)
    begin
      if (enhanced_enable)
        mask_d = wr_data;
      else
        mask_d = (interrupt_mask_q & `MASK_ENH_BITS) |
                 (wr_data & ~`MASK_ENH_BITS);
    end
  end

  // Wake-up and GPIO carry no code; wake-up drives the output only, GPIO also source bit 6
  // Priority encode pending enabled sources
  // Lower sources wait behind the highest
  always @*
  begin
    if (interrupt_mask_q[`MASK_LINE_STAT] && (ls_err_q || overrun_q))
      code_d = `SRC_LINE_STAT;
    else if (interrupt_mask_q[`MASK_RX_DATA] && timeout_q)
      code_d = `SRC_RX_TIMEOUT;
    else if (interrupt_mask_q[`MASK_RX_DATA] && rx_trig)
      code_d = `SRC_RX_DATA;
    else if (interrupt_mask_q[`MASK_TX_READY] && tx_ready_q)
      code_d = `SRC_TX_READY;
    else if (interrupt_mask_q[`MASK_MODEM] && (|modem_delta))
      code_d = `SRC_MODEM;
    // Stop character gated by mask bit 5
    else if (enhanced_enable && interrupt_mask_q[`MASK_XOFF] &&
             (flow_char_q || special_q))
      code_d = `SRC_FLOW_CHAR;
    else if (enhanced_enable && flow_pin_q &&
             (interrupt_mask_q[`MASK_RTS] || interrupt_mask_q[`MASK_CTS]))
      code_d = `SRC_FLOW_PIN;
    else
      code_d = `SRC_NONE;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpio_s1_q          <= 8'h00;
      gpio_s2_q          <= 8'h00;
      gpio_prev_q        <= 8'h00;
      cts_s1_q           <= 1'b0;
      cts_s2_q           <= 1'b0;
      cts_prev_q         <= 1'b0;
      rts_prev_q         <= 1'b0;
      ls_err_q           <= 1'b0;
      overrun_q          <= 1'b0;
      tx_ready_q         <= 1'b0;
      tx_empty_prev_q    <= 1'b0;
      flow_char_q        <= 1'b0;
      special_q          <= 1'b0;
      flow_pin_q         <= 1'b0;
      wake_q             <= 1'b0;
      gpio_q             <= 1'b0;
      timeout_q          <= 1'b0;
      timeout_cnt_q      <= 10'h000;
      head_err_prev_q    <= 1'b0;
      data_rd_prev_q     <= 1'b0;
      sync_fill_q        <= 2'b00;
      interrupt_mask_q   <= `MASK_RESET;
      interrupt_source_q <= {2'b00, `SRC_NONE};
      line_status_q      <= 8'h00;
      irq_q              <= 1'b0;
      sleep_enable_q     <= 1'b0;
    end
    else
    begin
      gpio_s1_q   <= gpio_in;
      gpio_s2_q   <= gpio_s1_q;
      gpio_prev_q <= gpio_act;
      cts_s1_q    <= cts_pin;
      cts_s2_q    <= cts_s1_q;
      cts_prev_q  <= cts_s2_q;
      rts_prev_q  <= rts_pin;
      head_err_prev_q <= head_err;
      data_rd_prev_q  <= rd_data;
      if (sync_fill_q != 2'b11)
        sync_fill_q <= sync_fill_q + 2'b01;
      interrupt_mask_q <= mask_d;
      sleep_enable_q   <= mask_d[`MASK_SLEEP];

      // Line status: overrun at once, errors per mode
      if (overrun_event)
        overrun_q <= 1'b1;
      else if (rd_ls)
        overrun_q <= 1'b0;
      if (err_set)
        ls_err_q <= 1'b1;
      else if (rd_ls)
        ls_err_q <= 1'b0;

      // Set on trigger edge or when mask bit goes on
      // Cleared by source read or data write
      // Source read clears only while shown; a read that
      // reported another source leaves this one queued
      tx_empty_prev_q <= tx_trig;
      if ((tx_trig && !tx_empty_prev_q) ||
          (tx_trig && mask_d[`MASK_TX_READY] &&
           !interrupt_mask_q[`MASK_TX_READY]))
        tx_ready_q <= 1'b1;
      else if ((rd_src && code_d == `SRC_TX_READY) || wr_data_r)
        tx_ready_q <= 1'b0;

      if (flow_char_event)
        flow_char_q <= 1'b1;
      else if (rd_src)
        flow_char_q <= 1'b0;
      // A new character ends a special-character event
      if (special_char_event)
        special_q <= 1'b1;
      else if (rd_src || rx_push)
        special_q <= 1'b0;

      // RTS or CTS rise
      // Modem status read clears both pin change events
      if ((rts_rise && interrupt_mask_q[`MASK_RTS]) ||
          (cts_rise && interrupt_mask_q[`MASK_CTS]))
        flow_pin_q <= 1'b1;
      else if (rd_ms)
        flow_pin_q <= 1'b0;

      // Wake-up flag, read of source clears
      if (wake_event && wake_enable)
        wake_q <= 1'b1;
      else if (rd_src)
        wake_q <= 1'b0;

      // Level register read clears
      if (gpio_rise)
        gpio_q <= 1'b1;
      else if (rd_gpio)
        gpio_q <= 1'b0;

      // Counter parks at the limit; ten bits cover 4*15+12
      // Timeout counter, restarted by any traffic
      if (!rx_has || rx_push || rd_data)
        timeout_cnt_q <= 10'h000;
      else if (rx_bit_tick && timeout_cnt_q != timeout_lim)
        timeout_cnt_q <= timeout_cnt_q + 10'h001;
      if (rx_has && rx_bit_tick && timeout_cnt_q + 10'h001 == timeout_lim)
        timeout_q <= 1'b1;
      else if (rd_data)
        timeout_q <= 1'b0;

      // Registered copy, one cycle behind its inputs
      // Data ready follows FIFO occupancy
      line_status_q <= {rx_errored_in_fifo, tx_empty & tx_shift_empty,
                        tx_empty, rx_head_break, rx_head_framing_err,
                        rx_head_parity_err, overrun_q, rx_has};

      // Receive data code while trigger met
      interrupt_source_q <= {fifo_enable, fifo_enable ^ gpio_q, code_d};
      // Modem deltas through code_d
      // Wake-up has no code, so only the output shows it
      irq_q <= (code_d != `SRC_NONE) || gpio_q || wake_q;
    end
  end

endmodule

/* sim/uart_irq_monitor.sv */
module uart_irq_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [2:0] addr,
  input wire logic       wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic       fifo_enable,
  input wire logic       enhanced_enable,
  input wire logic       overrun_event,
  input wire logic       rx_push,
  input wire logic [7:0] tx_fill,
  input wire logic       tx_shift_empty,
  input wire logic [7:0] interrupt_mask_q,
  input wire logic [7:0] interrupt_source_q,
  input wire logic [7:0] line_status_q,
  input wire logic       irq_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence mask_wr_s;
    wr_stb && addr == 3'h1;
  endsequence
  // Both transmit stages idle for two samples
  sequence tx_idle_s;
    (tx_fill == 8'h00 && tx_shift_empty) [*2];
  endsequence
  mask_write_a: assert property (
    mask_wr_s |=> interrupt_mask_q[3:0] == $past(wr_data[3:0]))
    else $error("mask low nibble not written");
  mask_refuse_a: assert property (
    wr_stb && addr == 3'h1 && !enhanced_enable |=>
      $stable(interrupt_mask_q[7:4]))
    else $error("mask high nibble written without enhanced mode");
  overrun_raise_a: assert property (
    overrun_event && interrupt_mask_q[2] |->
      ##[1:2] line_status_q[1] && interrupt_source_q[5:0] == 6'h06)
    else $error("overrun did not raise line status code");
  data_ready_a: assert property (
    rx_push |-> ##[1:2] line_status_q[0])
    else $error("data ready not set on receive push");
  tx_empty_a: assert property (
    tx_idle_s |-> line_status_q[6] && line_status_q[5])
    else $error("transmit empty bits not reported");
  fifo_flag_a: assert property (
    1'b1 |=> interrupt_source_q[7] == $past(fifo_enable))
    else $error("source bit 7 does not follow fifo enable");
  enh_hidden_a: assert property (
    !enhanced_enable |=> interrupt_source_q[5:4] == 2'b00)
    else $error("flow codes shown without enhanced mode");
  irq_pending_a: assert property (
    !interrupt_source_q[0] |-> irq_q)
    else $error("pending source without interrupt output");
endmodule

bind uart_interrupt_mask_and_priority uart_irq_monitor uart_irq_monitor_inst (.*);

/* sim/host_model.sv */
module host_model (
  input  wire logic clk,
  output logic [2:0] addr,
  output logic       rd_stb,
  output logic       wr_stb,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {addr, rd_stb, wr_stb, wr_data} = '0;
  end
  // One-cycle strobe; released lines show inverted values
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr_data = d;
    wr_stb = w;
    rd_stb = !w;
    @(negedge clk);
    {wr_stb, rd_stb} = 2'b00;
    addr = ~a;
    wr_data = ~d;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a);
    acc(1'b0, a, 8'h00);
  endtask
endmodule

/* sim/tb.sv */
`include "uart_irq_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, rd_stb, wr_stb, irq_q, sleep_enable_q;
  logic [2:0] addr;
  logic [3:0] char_bits, modem_delta;
  logic [7:0] wr_data, rx_fill, rx_trigger, tx_fill, tx_trigger, gpio_in;
  logic [7:0] gpio_polarity, gpio_int_mask, mk, w;
  logic [7:0] interrupt_mask_q, interrupt_source_q, line_status_q;
  logic       fifo_enable, enhanced_enable, enh_error_at_entry, wake_enable;
  logic       auto_rts_enable, auto_cts_enable, rx_push, rx_push_error;
  logic       rx_errored_in_fifo, rx_head_parity_err, rx_head_break;
  logic       rx_head_framing_err, overrun_event, rx_bit_tick, cts_pin;
  logic       flow_char_event, special_char_event, rts_pin, wake_event;
  logic       tx_shift_empty;
  int         fails, checked, seed, n;
  host_model host_inst (.clk, .addr, .rd_stb, .wr_stb, .wr_data);
  uart_interrupt_mask_and_priority uart_interrupt_mask_and_priority_inst (.*);
  task automatic print_verdict();
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Bit 6 mirrors bit 7 while no GPIO event pends
  task automatic see(input logic [5:0] c);
    tick(3);
    cmp(interrupt_source_q, {fifo_enable, fifo_enable, c});
  endtask
  function automatic logic [7:0] exp_mask(logic [7:0] o, d, logic e);
    return e ? d : {o[7:4], d[3:0]};
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial
  begin
    seed = 32'hdff49a77;
    {rst_n, fifo_enable, enhanced_enable, enh_error_at_entry, wake_enable,
     auto_rts_enable, auto_cts_enable, rx_push, rx_push_error, cts_pin,
     rx_errored_in_fifo, rx_head_parity_err, rx_head_break, rts_pin,
     rx_head_framing_err, overrun_event, rx_bit_tick, flow_char_event,
     special_char_event, wake_event, mk} = '0;
    {rx_fill, gpio_in, gpio_polarity, gpio_int_mask, modem_delta} = '0;
    {rx_trigger, tx_trigger, tx_fill} = {8'h04, 8'h04, 8'h08};
    {char_bits, tx_shift_empty} = {4'h8, 1'b1};
    tick(3);
    cmp(interrupt_mask_q, 8'h00);
    cmp(interrupt_source_q, 8'h01);
    rst_n = 1'b1;
    repeat (8)
    begin
      w = $random(seed);
      enhanced_enable = $random(seed);
      host_inst.wr(`ADDR_MASK, w);
      mk = exp_mask(mk, w, enhanced_enable);
      tick(2);
      cmp(interrupt_mask_q, mk);
    end
    enhanced_enable = 1'b1;
    host_inst.wr(`ADDR_MASK, 8'h10);
    tick(2);
    cmp({7'h00, sleep_enable_q}, 8'h01);
    host_inst.wr(`ADDR_MASK, 8'h00);
    {enhanced_enable, fifo_enable, tx_fill} = {2'b01, 8'h00};
    tick(3);
    cmp(line_status_q & 8'h60, 8'h60);
    cmp({7'h00, irq_q}, 8'h00);
    host_inst.wr(`ADDR_MASK, 8'h02);
    see(`SRC_TX_READY);
    host_inst.rd(`ADDR_SOURCE);
    see(`SRC_NONE);
    tx_fill = 8'h08;
    tick(2);
    tx_fill = 8'h00;
    see(`SRC_TX_READY);
    host_inst.wr(`ADDR_DATA, 8'h5a);
    see(`SRC_NONE);
    tx_fill = 8'h08;
    host_inst.wr(`ADDR_MASK, 8'h0d);
    modem_delta = 4'h1 << w[1:0];
    see(`SRC_MODEM);
    rx_fill = 8'h01;
    pulse(rx_push);
    tick(2);
    cmp({7'h00, line_status_q[0]}, 8'h01);
    rx_fill = 8'h04;
    see(`SRC_RX_DATA);
    pulse(overrun_event);
    see(`SRC_LINE_STAT);
    host_inst.rd(`ADDR_LINE_STATUS);
    see(`SRC_RX_DATA);
    rx_fill = 8'h03;
    see(`SRC_MODEM);
    modem_delta = 4'h0;
    see(`SRC_NONE);
    rx_fill = 8'h00;
    tick(2);
    cmp({7'h00, line_status_q[0]}, 8'h00);
    host_inst.wr(`ADDR_MASK, 8'h01);
    char_bits = 4'h5 + {2'b00, w[3:2]};
    n = 4 * char_bits + 12;
    rx_fill = 8'h01;
    pulse(rx_push);
    repeat (n - 1) pulse(rx_bit_tick);
    see(`SRC_NONE);
    pulse(rx_bit_tick);
    see(`SRC_RX_TIMEOUT);
    host_inst.rd(`ADDR_DATA);
    rx_fill = 8'h00;
    see(`SRC_NONE);
    {gpio_int_mask, gpio_in} = {8'h04, 8'h04};
    tick(5);
    cmp(interrupt_source_q, 8'h81);
    cmp({7'h00, irq_q}, 8'h01);
    host_inst.rd(`ADDR_GPIO_LEVEL);
    tick(3);
    cmp({7'h00, irq_q}, 8'h00);
    gpio_polarity = 8'h04;
    tick(5);
    gpio_in = 8'h00;
    tick(5);
    cmp({7'h00, irq_q}, 8'h01);
    host_inst.rd(`ADDR_GPIO_LEVEL);
    tick(3);
    cmp({7'h00, irq_q}, 8'h00);
    enhanced_enable = 1'b1;
    host_inst.wr(`ADDR_MASK, 8'h60);
    pulse(flow_char_event);
    see(`SRC_FLOW_CHAR);
    host_inst.rd(`ADDR_SOURCE);
    see(`SRC_NONE);
    {auto_rts_enable, rts_pin} = 2'b11;
    see(`SRC_FLOW_PIN);
    host_inst.rd(`ADDR_MODEM_STAT);
    see(`SRC_NONE);
    host_inst.wr(`ADDR_MASK, 8'he0);
    {auto_cts_enable, cts_pin} = 2'b11;
    tick(2);
    see(`SRC_FLOW_PIN);
    host_inst.rd(`ADDR_MODEM_STAT);
    see(`SRC_NONE);
    pulse(special_char_event);
    see(`SRC_FLOW_CHAR);
    rx_fill = 8'h01;
    pulse(rx_push);
    rx_fill = 8'h00;
    see(`SRC_NONE);
    wake_enable = 1'b1;
    pulse(wake_event);
    tick(2);
    cmp(interrupt_source_q, 8'hc1);
    cmp({7'h00, irq_q}, 8'h01);
    host_inst.rd(`ADDR_SOURCE);
    tick(2);
    cmp({7'h00, irq_q}, 8'h00);
    host_inst.wr(`ADDR_MASK, 8'h04);
    {rx_head_parity_err, rx_errored_in_fifo} = 2'b11;
    see(`SRC_LINE_STAT);
    cmp(line_status_q & 8'h9c, 8'h84);
    host_inst.rd(`ADDR_LINE_STATUS);
    see(`SRC_NONE);
    {rx_head_parity_err, rx_errored_in_fifo} = 2'b00;
    {enh_error_at_entry, rx_push_error, rx_fill} = {2'b11, 8'h01};
    pulse(rx_push);
    see(`SRC_LINE_STAT);
    host_inst.rd(`ADDR_LINE_STATUS);
    see(`SRC_NONE);
    rx_fill = 8'h00;
    host_inst.wr(`ADDR_MASK, 8'h20);
    enhanced_enable = 1'b0;
    pulse(flow_char_event);
    see(`SRC_NONE);
    print_verdict();
  end
endmodule
